// [include/hpc_map.vh]
// Constants for the host pin configuration register block.
// Assumes inclusion by bare name from design files only.
`ifndef HPC_MAP_VH
`define HPC_MAP_VH

`define HPC_CMD_READ      8'h20
`define HPC_CMD_WRITE     8'ha0
`define HPC_RESET_VAL     16'h0028
`define HPC_WR_MASK       16'h1fff
`define HPC_BIT_PD1       12
`define HPC_BIT_KEEPCLK   11
`define HPC_BIT_ONCHIPOC  10
`define HPC_BIT_SHIRQ     9
`define HPC_BIT_ACKMODE   8
`define HPC_BIT_SHDMA     7
`define HPC_BIT_ACKPOL    6
`define HPC_BIT_REQPOL    5
`define HPC_BW_HI         4
`define HPC_BW_LO         3
`define HPC_BIT_IRQPOL    2
`define HPC_BIT_IRQEDGE   1
`define HPC_BIT_IRQEN     0
`define HPC_BW_16BIT      2'h1
`define HPC_EDGE_PULSE_CYC 4'h8

`endif

// [verilog/hpc_host_pin_config.v]
// Host pin configuration register and the pin routing it steers.
// Assumes a command/data port already decoded from the parallel bus, and
// interrupt, DMA and pin signals from sibling logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "hpc_map.vh"

module hpc_host_pin_config (
  input  wire        sys_clk_in,            // 200 MHz clock
  input  wire        rstn_in,               // Async reset, active low
  input  wire        cmd_valid_in,          // Command strobe, one cycle
  input  wire [7:0]  cmd_code_in,           // Command code
  input  wire [15:0] cmd_wdata_in,          // Write data
  output reg  [15:0] cmd_rdata_out,         // Read data
  output reg         cmd_rvalid_out,        // Read data valid pulse
  input  wire        dual_role_select_pin_in, // Mode-select pin
  input  wire        role_sense_pin_in,     // Role-sense pin
  input  wire        local_plus_pulldown_in,  // From dual-role control reg
  input  wire        local_minus_pulldown_in, // From dual-role control reg
  output wire        port1_plus_pd_out,     // Pull-down enable, plus line
  output wire        port1_minus_pd_out,    // Pull-down enable, minus line
  output wire        keep_clock_in_suspend_out, // Clock must keep running
  input  wire        ext_overcurrent_in,    // External digital detect
  input  wire        ana_overcurrent_in,    // On-chip analog detect
  output wire        overcurrent_detect_out,// Selected over-current
  input  wire        host_ctrl_irq_in,      // Host controller interrupt
  input  wire        peripheral_ctrl_irq_in,// Peripheral controller interrupt
  input  wire        cpu_irq_enable_in,     // From cpu irq enable register
  output reg         irq_pin_a_out,         // Interrupt pin A
  output reg         irq_pin_b_out,         // Interrupt pin B, active low
  input  wire        host_ctrl_dreq_in,     // Host DMA request
  input  wire        peripheral_ctrl_dreq_in, // Peripheral DMA request
  output reg         dma_req_a_out,         // DMA request pin A
  output reg         dma_req_b_out,         // DMA request pin B, active high
  input  wire        dma_ack_a_in,          // DMA ack pin A
  input  wire        dma_ack_b_in,          // DMA ack pin B, active low
  output wire        host_ctrl_dack_out,    // Host ack, active high
  output wire        peripheral_ctrl_dack_out, // Peripheral ack, active high
  output wire        ack_strobe_mode_out,   // Ack qualifies strobes when low
  output wire [1:0]  cpu_bus_width_out      // Bus width field
);

  ////////////////////////////////////////////////////////////////////////
  // Storage and internal nets
  reg  [15:0] cfg_q;
  reg  [1:0]  dsel_s1_q;
  reg  [1:0]  dsel_s2_q;
  reg  [1:0]  ack_s1_q;
  reg  [1:0]  ack_s2_q;
  reg         irq_a_prev_q;
  reg  [3:0]  pulse_cnt_q;
  reg  [3:0]  pulse_cnt_d;
  reg         irq_a_act;
  reg         irq_b_act;
  reg         req_a_act;
  reg         irq_pin_a_d;
  reg         irq_pin_b_d;
  reg         dma_req_a_d;
  reg         dma_req_b_d;
  wire        wr_hit;
  wire        rd_hit;
  wire        host_mode;
  wire        ack_a_act;
  wire        ack_b_act;

  ////////////////////////////////////////////////////////////////////////
  // Command decode; any other code is dropped without a reply
  assign wr_hit = cmd_valid_in & (cmd_code_in == `HPC_CMD_WRITE);
  assign rd_hit = cmd_valid_in & (cmd_code_in == `HPC_CMD_READ);

  ////////////////////////////////////////////////////////////////////////
  // Configuration word; reserved width codes are kept as written
  // Bits 15..13 are not built, so the mask keeps them reading zero
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_q <= `HPC_RESET_VAL;
    end else if (wr_hit) begin
      cfg_q <= cmd_wdata_in & `HPC_WR_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read reply; a read beside a write returns the old word
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_rdata_out  <= 16'h0000;
      cmd_rvalid_out <= 1'b0;
    end else begin
      cmd_rvalid_out <= rd_hit;
      if (rd_hit) begin
        cmd_rdata_out <= cfg_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode pins; first stage read only by second
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dsel_s1_q <= 2'h0;
      dsel_s2_q <= 2'h0;
    end else begin
      dsel_s1_q <= {dual_role_select_pin_in, role_sense_pin_in};
      dsel_s2_q <= dsel_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ack pins; reset to the idle level of an active-low strobe
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_s1_q <= 2'h3;
      ack_s2_q <= 2'h3;
    end else begin
      ack_s1_q <= {dma_ack_a_in, dma_ack_b_in};
      ack_s2_q <= ack_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pull-downs; a role change shows two cycles after the pins move
  assign host_mode = dsel_s2_q[1] & ~dsel_s2_q[0];
  assign port1_plus_pd_out  = host_mode ? cfg_q[`HPC_BIT_PD1]
                                        : local_plus_pulldown_in;
  assign port1_minus_pd_out = host_mode ? cfg_q[`HPC_BIT_PD1]
                                        : local_minus_pulldown_in;

  ////////////////////////////////////////////////////////////////////////
  // Suspend clock, over-current source and reported fields
  assign keep_clock_in_suspend_out = cfg_q[`HPC_BIT_KEEPCLK];
  assign overcurrent_detect_out = cfg_q[`HPC_BIT_ONCHIPOC] ? ana_overcurrent_in
                                                          : ext_overcurrent_in;
  assign ack_strobe_mode_out = cfg_q[`HPC_BIT_ACKMODE];
  assign cpu_bus_width_out   = cfg_q[`HPC_BW_HI:`HPC_BW_LO];

  ////////////////////////////////////////////////////////////////////////
  // DMA acknowledge routing and polarity
  assign ack_a_act = ack_s2_q[1] ~^ cfg_q[`HPC_BIT_ACKPOL];
  assign ack_b_act = ~ack_s2_q[0];
  assign host_ctrl_dack_out = ack_a_act;
  assign peripheral_ctrl_dack_out = cfg_q[`HPC_BIT_SHDMA] ? ack_a_act : ack_b_act;

  ////////////////////////////////////////////////////////////////////////
  // DMA request next values
  always @* begin
    req_a_act   = host_ctrl_dreq_in
                | (cfg_q[`HPC_BIT_SHDMA] & peripheral_ctrl_dreq_in);
    dma_req_a_d = req_a_act ~^ cfg_q[`HPC_BIT_REQPOL];
    dma_req_b_d = peripheral_ctrl_dreq_in & ~cfg_q[`HPC_BIT_SHDMA];
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt next values; edge mode starts an 8-cycle pulse on pin A at each rising cause, restarting any pulse in progress
  // A cause held high gives one pulse only; it must fall to rearm
  always @* begin
    irq_a_act = cfg_q[`HPC_BIT_SHIRQ] ? (host_ctrl_irq_in | peripheral_ctrl_irq_in)
                                      : host_ctrl_irq_in;
    irq_a_act = irq_a_act & cpu_irq_enable_in & cfg_q[`HPC_BIT_IRQEN];
    irq_b_act = peripheral_ctrl_irq_in & ~cfg_q[`HPC_BIT_SHIRQ];
    irq_pin_b_d = ~irq_b_act;
    pulse_cnt_d = pulse_cnt_q;
    if (irq_a_act && !irq_a_prev_q) begin
      pulse_cnt_d = `HPC_EDGE_PULSE_CYC;
    end else if (pulse_cnt_q != 4'h0) begin
      pulse_cnt_d = pulse_cnt_q - 4'h1;
    end
    irq_pin_a_d = cfg_q[`HPC_BIT_IRQEDGE] ? (pulse_cnt_d != 4'h0)
                                          : irq_a_act;
    irq_pin_a_d = irq_pin_a_d ~^ cfg_q[`HPC_BIT_IRQPOL];
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge detector state; idle low so no false edge follows reset
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_a_prev_q <= 1'b0;
      pulse_cnt_q  <= 4'h0;
    end else begin
      irq_a_prev_q <= irq_a_act;
      pulse_cnt_q  <= pulse_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt pins; reset to inactive for the power-up polarity
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_pin_a_out <= 1'b1;
      irq_pin_b_out <= 1'b1;
    end else begin
      irq_pin_a_out <= irq_pin_a_d;
      irq_pin_b_out <= irq_pin_b_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // DMA request pins; request A resets inactive for active-high
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dma_req_a_out <= 1'b0;
      dma_req_b_out <= 1'b0;
    end else begin
      dma_req_a_out <= dma_req_a_d;
      dma_req_b_out <= dma_req_b_d;
    end
  end

endmodule
`default_nettype wire

// [tb/hpc_host_pin_config_chk.sv]
// Assertions on the host pin config block, shadowing its register.
// Assumes binding to the block top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module hpc_chk (
  input wire logic        sys_clk_in, rstn_in, cmd_valid_in, cmd_rvalid_out, // Clock, reset, strobes
  input wire logic [7:0]  cmd_code_in,                 // Command
  input wire logic [15:0] cmd_wdata_in, cmd_rdata_out, // Data
  input wire logic [1:0]  cpu_bus_width_out,           // Width field
  input wire logic        keep_clock_in_suspend_out, ack_strobe_mode_out, ext_overcurrent_in, ana_overcurrent_in,
  input wire logic        overcurrent_detect_out, peripheral_ctrl_irq_in, irq_pin_b_out, host_ctrl_dreq_in,
  input wire logic        peripheral_ctrl_dreq_in, dma_req_a_out, dma_req_b_out, dual_role_select_pin_in,
  input wire logic        role_sense_pin_in, port1_plus_pd_out, port1_minus_pd_out, local_plus_pulldown_in,
  input wire logic        local_minus_pulldown_in  // Pins
);
  logic [15:0] cfg_q;
  always @(posedge sys_clk_in or negedge rstn_in)
    if (!rstn_in) cfg_q <= 16'h0028;
    else if (cmd_valid_in && cmd_code_in == 8'ha0) cfg_q <= cmd_wdata_in & 16'h1fff;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  property p_rd; cmd_valid_in && cmd_code_in == 8'h20 |=> cmd_rvalid_out && cmd_rdata_out == $past(cfg_q); endproperty
  a_rd: assert property (p_rd) else $error("bad read reply");
  property p_oc; overcurrent_detect_out == (cfg_q[10] ? ana_overcurrent_in : ext_overcurrent_in); endproperty
  a_oc: assert property (p_oc) else $error("bad overcurrent source");
  property p_fld;
    {keep_clock_in_suspend_out, ack_strobe_mode_out, cpu_bus_width_out} == {cfg_q[11], cfg_q[8], cfg_q[4:3]};
  endproperty
  a_fld: assert property (p_fld) else $error("bad field outputs");
  property p_irqb; 1 |=> irq_pin_b_out == !$past(!cfg_q[9] && peripheral_ctrl_irq_in); endproperty
  a_irqb: assert property (p_irqb) else $error("bad irq pin b");
  property p_dqb; 1 |=> dma_req_b_out == $past(!cfg_q[7] && peripheral_ctrl_dreq_in); endproperty
  a_dqb: assert property (p_dqb) else $error("bad dma req b");
  property p_dqa; 1 |=> dma_req_a_out == !$past(cfg_q[5] ^ (host_ctrl_dreq_in | cfg_q[7] & peripheral_ctrl_dreq_in)); endproperty
  a_dqa: assert property (p_dqa) else $error("bad dma req a");
  property p_pdl; !dual_role_select_pin_in [*3] |-> {port1_plus_pd_out, port1_minus_pd_out} ==
    {local_plus_pulldown_in, local_minus_pulldown_in}; endproperty
  a_pdl: assert property (p_pdl) else $error("bad local pulldowns");
  property p_pdh; (dual_role_select_pin_in && !role_sense_pin_in) [*3] |-> port1_plus_pd_out == cfg_q[12] &&
    port1_minus_pd_out == cfg_q[12]; endproperty
  a_pdh: assert property (p_pdh) else $error("bad host pulldowns");
  c_wr: cover property (cmd_valid_in && cmd_code_in == 8'ha0);
  c_rd: cover property (cmd_rvalid_out);
  c_sh: cover property (cfg_q[9] && peripheral_ctrl_irq_in);
endmodule
bind hpc_host_pin_config hpc_chk u_hpc_chk (.*);
`default_nettype wire

// [tb/hpc_cpu_model.sv]
// Microprocessor side of the command port.
// Assumes commands launch just after a rising edge, one per word.
`timescale 1ns/1ps
`default_nettype none
module hpc_cpu_model (
  input  wire logic        clk_in,             // Clock
  input  wire logic [15:0] rdata_in,           // Read data
  input  wire logic        rvalid_in,          // Read valid
  output var  logic        valid_out = 1'b0,   // Strobe
  output var  logic [7:0]  code_out = 8'h00,   // Command
  output var  logic [15:0] wdata_out = 16'h0000 // Write data
);
  task automatic cmd(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_in);
    valid_out <= 1'b1;
    code_out  <= c;
    wdata_out <= d;
    @(posedge clk_in);
    valid_out <= 1'b0;
    wdata_out <= ~d; // Stale data must not pass as valid
  endtask
  task automatic rd(output logic [15:0] d);
    cmd(8'h20, 16'h0000);
    #1 d = rvalid_in ? rdata_in : 16'hxxxx;
  endtask
endmodule
`default_nettype wire

// [tb/host_pin_config_register_tb.sv]
// Self-checking bench for the host pin config register.
// Assumes the cpu model drives commands; pins driven here.
`timescale 1ns/1ps
`default_nettype none
module host_pin_config_register_tb;
  logic sys_clk_in = 1'b0, rstn_in = 1'b0, hi = 1'b0, pi = 1'b0;
  logic dual_role_select_pin_in = 1'b1, local_plus_pulldown_in = 1'b1, local_minus_pulldown_in = 1'b0;
  logic cmd_valid_in, cmd_rvalid_out, irq_pin_a_out, host_ctrl_dack_out, pdack, pd_p, pd_m;
  logic [7:0] cmd_code_in;
  logic [15:0] cmd_wdata_in, cmd_rdata_out, got;
  int mismatches = 0, checks_done = 0;
  logic [15:0] pat [3] = '{16'he6ad, 16'h1c48, 16'h0009}; // Bit 8 clear, width 01
  always #2.5 sys_clk_in = ~sys_clk_in;
  hpc_host_pin_config u_hpc_host_pin_config (.*, .role_sense_pin_in(1'b0), .cpu_irq_enable_in(1'b1),
    .dma_ack_b_in(1'b1), .host_ctrl_irq_in(hi), .peripheral_ctrl_irq_in(pi), .host_ctrl_dreq_in(pi),
    .peripheral_ctrl_dreq_in(hi), .ext_overcurrent_in(hi), .ana_overcurrent_in(pi), .dma_ack_a_in(hi),
    .port1_plus_pd_out(pd_p), .port1_minus_pd_out(pd_m), .keep_clock_in_suspend_out(), .overcurrent_detect_out(),
    .irq_pin_b_out(), .dma_req_a_out(), .dma_req_b_out(), .peripheral_ctrl_dack_out(pdack),
    .ack_strobe_mode_out(), .cpu_bus_width_out());
  hpc_cpu_model u_hpc_cpu_model (.clk_in(sys_clk_in), .rdata_in(cmd_rdata_out), .rvalid_in(cmd_rvalid_out),
    .valid_out(cmd_valid_in), .code_out(cmd_code_in), .wdata_out(cmd_wdata_in));
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk_in);
    mismatches++;
    conclude;
  end
  initial begin
    repeat (3) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    u_hpc_cpu_model.rd(got);
    cmp(got, 16'h0028);
    u_hpc_cpu_model.cmd(8'h21, 16'hffff);
    u_hpc_cpu_model.rd(got);
    cmp(got, 16'h0028);
    foreach (pat[i]) begin
      u_hpc_cpu_model.cmd(8'ha0, pat[i]);
      u_hpc_cpu_model.rd(got);
      cmp(got, pat[i] & 16'h1fff);
      for (int k = 1; k < 3; k++) begin
        @(posedge sys_clk_in);
        {hi, pi} <= k[1:0];
        repeat (4) @(posedge sys_clk_in);
        #1 cmp({15'h0, irq_pin_a_out}, {15'h0, ~((pat[i][0] & (hi | pat[i][9] & pi)) ^ pat[i][2])});
        cmp({15'h0, host_ctrl_dack_out}, {15'h0, hi == pat[i][6]});
        cmp({15'h0, pdack}, {15'h0, pat[i][7] & (hi == pat[i][6])});
        cmp({14'h0, pd_p, pd_m}, {14'h0, pat[i][12], pat[i][12]});
      end
    end
    {hi, pi} <= 2'h0;
    u_hpc_cpu_model.cmd(8'ha0, 16'h000f);
    @(posedge sys_clk_in);
    hi <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1 cmp({15'h0, irq_pin_a_out}, 16'h0001);
    repeat (6) @(posedge sys_clk_in);
    #1 cmp({15'h0, irq_pin_a_out}, 16'h0001);
    repeat (2) @(posedge sys_clk_in);
    #1 cmp({15'h0, irq_pin_a_out}, 16'h0000);
    @(posedge sys_clk_in);
    dual_role_select_pin_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    #1 cmp({14'h0, pd_p, pd_m}, 16'h0002);
    @(posedge sys_clk_in);
    local_minus_pulldown_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    #1 cmp({14'h0, pd_p, pd_m}, 16'h0003);
    conclude;
  end
endmodule
`default_nettype wire
